// *** hdl/phy_event_irq.sv ***
// Event pending bits, interrupt gating and error counters of the PHY
//
// Functional notes
// - Pending bit set on event since last read
// - Enabled event raises an interrupt
// - Master control must also permit interrupts
// - Pending latches regardless of any enable
// - Bit 14 energy detect, cleared on read
// - Bit 13 link change, cleared on read
// - Bit 12 speed change, cleared on read
// - Bit 11 duplex change, cleared on read
// - Bit 10 autoneg done, cleared on read
// - Bit 9 false carrier half-full, read clears
// - Bit 8 receive error half-full, read clears
// - Bits 6:0 read-write enables, reset zero
// - Reserved bits ignore writes, read zero
// - False carrier tally counts, read clears
// - False carrier tally saturates at FFh
// - Receive errors counted during valid carrier
// - At most one count per carrier event
// - No count when collision in carrier
// - Receive error tally saturates, not wraps
// - Master enable bit 1 gates event interrupts
// - Bit 0 makes shared pin interrupt output
// - Bit 2 forces interrupt while set
`timescale 1ns/1ns
`include "phy_event_consts.svh"
`default_nettype none
module phy_event_irq (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // Management register port (one cycle strobes)
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // Status levels from the PHY core
  input  wire logic        energy_i,
  input  wire logic        link_i,
  input  wire logic        speed_i,
  input  wire logic        duplex_i,
  input  wire logic        autoneg_done_i,
  // Receive path indications
  input  wire logic        false_carrier_i,
  input  wire logic        carrier_i,
  input  wire logic        symbol_err_i,
  input  wire logic        collision_i,
  // Shared power-down / interrupt pin
  input  wire logic        powerdown_or_irq_pin_i,
  output logic             powerdown_or_irq_pin_o,
  output logic             powerdown_or_irq_pin_oe_o,
  output logic             powerdown_o
);
  localparam int NE = `EVT_COUNT;

  ////////////////////////////////////////////////////////////////
  // Register state
  logic [NE-1:0]        pend_q, pend_d;     // Pending bits, index 6 = energy
  logic [NE-1:0]        enab_q, enab_d;     // Per-event enables
  logic [`IMC_WIDTH-1:0] imc_q, imc_d;      // Master control bits
  logic [4:0]           stat_q, stat_d;     // Last seen status levels
  logic                 irq_q, irq_d;       // Registered interrupt
  logic [15:0]          rdata_q, rdata_d;   // Read data
  logic [2:0]           pd_sync_q;          // Pin synchroniser
  logic                 pd_q, pd_d;         // Filtered power-down level
  phy_event_pkg::car_state_e car_q, car_d;  // Carrier tracker
  logic                 car_err_q, car_err_d; // Error seen this carrier

  tally_if fc_t ();
  tally_if re_t ();

  sat_tally u_fc (.clk_i(clk_i), .resetn_i(resetn_i), .t(fc_t));
  sat_tally u_re (.clk_i(clk_i), .resetn_i(resetn_i), .t(re_t));

  // Decode helper used by every register access
  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    return a == o;
  endfunction

  logic rd_ese, rd_fc, rd_re, wr_ese, wr_imc;
  assign rd_ese = reg_rd_i && hit(reg_addr_i, `ESE_ADDR);
  assign rd_fc  = reg_rd_i && hit(reg_addr_i, `FCC_ADDR);
  assign rd_re  = reg_rd_i && hit(reg_addr_i, `REC_ADDR);
  assign wr_ese = reg_wr_i && hit(reg_addr_i, `ESE_ADDR);
  assign wr_imc = reg_wr_i && hit(reg_addr_i, `IMC_ADDR);

  ////////////////////////////////////////////////////////////////
  // Event detection: status level changes and counter crossings
  logic [4:0]    cur_stat;
  logic [NE-1:0] evt;
  assign cur_stat = {energy_i, link_i, speed_i, duplex_i, autoneg_done_i};
  always_comb begin
    stat_d = cur_stat;
    evt[6] = energy_i & ~stat_q[4];
    evt[5] = link_i ^ stat_q[3];
    evt[4] = speed_i ^ stat_q[2];
    evt[3] = duplex_i ^ stat_q[1];
    evt[2] = autoneg_done_i & ~stat_q[0];
    evt[1] = fc_t.half;
    evt[0] = re_t.half;
  end

  ////////////////////////////////////////////////////////////////
  // Pending bits: set on event whatever the enables, clear on read,
  // and an event in the reading cycle wins so nothing is lost
  always_comb begin
    pend_d = (rd_ese ? '0 : pend_q) | evt;
    enab_d = wr_ese ? reg_wdata_i[NE-1:0] : enab_q;
    imc_d  = wr_imc ? reg_wdata_i[`IMC_WIDTH-1:0] : imc_q;
  end

  ////////////////////////////////////////////////////////////////
  // Receive error qualification: at most one count per clean carrier event
  always_comb begin
    car_d     = car_q;
    car_err_d = car_err_q;
    unique case (car_q)
      phy_event_pkg::CAR_IDLE: begin
        car_err_d = 1'b0;
        if (carrier_i) car_d = collision_i ? phy_event_pkg::CAR_DONE
                                           : phy_event_pkg::CAR_CLEAN;
        if (carrier_i && !collision_i) car_err_d = symbol_err_i;
      end
      phy_event_pkg::CAR_CLEAN: begin
        if (collision_i) car_d = phy_event_pkg::CAR_DONE;
        else if (!carrier_i) car_d = phy_event_pkg::CAR_IDLE;
        else car_err_d = car_err_q | symbol_err_i;
      end
      phy_event_pkg::CAR_DONE: begin
        // Collided carrier: wait it out without counting
        car_err_d = 1'b0;
        if (!carrier_i) car_d = phy_event_pkg::CAR_IDLE;
      end
      default: car_d = phy_event_pkg::CAR_IDLE;
    endcase
  end

  // Count at carrier end so a later collision can still veto it
  assign re_t.inc = (car_q == phy_event_pkg::CAR_CLEAN) && !carrier_i
                    && !collision_i && car_err_q;
  assign re_t.clr = rd_re;
  assign fc_t.inc = false_carrier_i;
  assign fc_t.clr = rd_fc;

  ////////////////////////////////////////////////////////////////
  // Interrupt and pin control
  always_comb begin
    irq_d = ((|(pend_d & enab_d)) && imc_d[`IMC_MASTER_BIT])
            || imc_d[`IMC_TEST_BIT];
    // Change counts once the last two sync stages agree
    pd_d  = (pd_sync_q[1] == pd_sync_q[2]) ? pd_sync_q[2] : pd_q;
  end

  // Read mux; reserved bits are zero by construction
  always_comb begin
    rdata_d = `REG_ZERO;
    if (reg_rd_i) begin
      unique case (1'b1)
        hit(reg_addr_i, `ESE_ADDR):
          rdata_d = {1'b0, pend_q, 1'b0, enab_q};
        hit(reg_addr_i, `IMC_ADDR):
          rdata_d = {13'h0000, imc_q};
        hit(reg_addr_i, `FCC_ADDR): rdata_d = {8'h00, fc_t.value};
        hit(reg_addr_i, `REC_ADDR): rdata_d = {8'h00, re_t.value};
        default: rdata_d = `REG_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pend_q    <= '0;
      enab_q    <= '0;
      imc_q     <= '0;
      stat_q    <= '0;
      irq_q     <= 1'b0;
      rdata_q   <= '0;
      pd_sync_q <= '0;
      pd_q      <= 1'b0;
      car_q     <= phy_event_pkg::CAR_IDLE;
      car_err_q <= 1'b0;
    end else begin
      pend_q    <= pend_d;
      enab_q    <= enab_d;
      imc_q     <= imc_d;
      stat_q    <= stat_d;
      irq_q     <= irq_d;
      rdata_q   <= rdata_d;
      pd_sync_q <= {pd_sync_q[1:0], powerdown_or_irq_pin_i};
      pd_q      <= pd_d;
      car_q     <= car_d;
      car_err_q <= car_err_d;
    end
  end

  // Pin is an output only when the pin-mode bit is set; oe low drives
  assign powerdown_or_irq_pin_oe_o = ~imc_q[`IMC_PIN_OE_BIT];
  assign powerdown_or_irq_pin_o    = irq_q;
  assign powerdown_o = ~imc_q[`IMC_PIN_OE_BIT] & pd_q;
  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  property p_irq_cause;
    @(posedge clk_i) disable iff (!resetn_i)
      irq_q |-> imc_q[`IMC_TEST_BIT]
                || (imc_q[`IMC_MASTER_BIT] && |(pend_q & enab_q));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without master");
  property p_test_irq;
    @(posedge clk_i) disable iff (!resetn_i)
      imc_q[`IMC_TEST_BIT] |-> irq_q;
  endproperty
  a_test_irq: assert property (p_test_irq) else $error("test irq missing");
  property p_latch;
    @(posedge clk_i) disable iff (!resetn_i) evt[5] |=> pend_q[5];
  endproperty
  a_latch: assert property (p_latch) else $error("link event lost");
  property p_cor;
    @(posedge clk_i) disable iff (!resetn_i)
      (rd_ese && evt == '0) |=> pend_q == '0;
  endproperty
  a_cor: assert property (p_cor) else $error("read did not clear");
  property p_enable;
    @(posedge clk_i) disable iff (!resetn_i)
      (|(pend_q & enab_q) && imc_q[`IMC_MASTER_BIT]) |-> irq_q;
  endproperty
  a_enable: assert property (p_enable) else $error("enabled pending no irq");
  property p_pin;
    @(posedge clk_i) disable iff (!resetn_i)
      imc_q[`IMC_PIN_OE_BIT] |-> !powerdown_or_irq_pin_oe_o && !powerdown_o;
  endproperty
  a_pin: assert property (p_pin) else $error("pin mode wrong");
  property p_rsv;
    @(posedge clk_i) disable iff (!resetn_i)
      ($past(rd_fc) || $past(rd_re)) |-> reg_rdata_o[15:8] == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  // Status word reserved bits sit above the pending field (bit 15) and between the pending and enable fields (bit 7)
  property p_rsv_stat;
    @(posedge clk_i) disable iff (!resetn_i)
      $past(rd_ese) |-> !reg_rdata_o[15] && !reg_rdata_o[7];
  endproperty
  a_rsv_stat: assert property (p_rsv_stat) else $error("status reserved bit set");
  property p_coll;
    @(posedge clk_i) disable iff (!resetn_i)
      (car_q == phy_event_pkg::CAR_DONE) |-> !re_t.inc;
  endproperty
  a_coll: assert property (p_coll) else $error("count during collision");
  // A collided carrier never returns to the counting state
  property p_coll_veto;
    @(posedge clk_i) disable iff (!resetn_i)
      collision_i |=> car_q != phy_event_pkg::CAR_CLEAN;
  endproperty
  a_coll_veto: assert property (p_coll_veto) else $error("collided carrier counted");
  // A count lands only on the cycle the carrier has just dropped
  property p_rx_end;
    @(posedge clk_i) disable iff (!resetn_i)
      re_t.inc |-> $past(carrier_i) && !carrier_i;
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("count inside carrier");
  property p_half_pend;
    @(posedge clk_i) disable iff (!resetn_i) fc_t.half |=> pend_q[1];
  endproperty
  a_half_pend: assert property (p_half_pend) else $error("half-full event lost");
  c_irq:  cover property (@(posedge clk_i) irq_q && !imc_q[`IMC_TEST_BIT]);
  c_rxe:  cover property (@(posedge clk_i) re_t.inc);
  c_read: cover property (@(posedge clk_i) rd_ese && |pend_q);
endmodule
`default_nettype wire

// *** common/phy_event_consts.svh ***
// Register offsets, field positions, widths and tally limits for the event block
`ifndef PHY_EVENT_CONSTS_SVH
`define PHY_EVENT_CONSTS_SVH
`define IMC_ADDR        5'h11
`define ESE_ADDR        5'h12
`define FCC_ADDR        5'h14
`define REC_ADDR        5'h15
`define IMC_PIN_OE_BIT  0
`define IMC_MASTER_BIT  1
`define IMC_TEST_BIT    2
`define IMC_WIDTH       3
`define EVT_COUNT       7
`define PEND_LSB        8
`define TALLY_WIDTH     8
`define TALLY_HALF      8'h80
`define TALLY_MAX       8'hff
`define REG_ZERO        16'h0000
`endif

// *** common/phy_event_pkg.sv ***
// Types shared by the event block
`default_nettype none
package phy_event_pkg;
  // Carrier event tracking states
  typedef enum logic [2:0] {
    CAR_IDLE  = 3'b001,
    CAR_CLEAN = 3'b010,
    CAR_DONE  = 3'b100
  } car_state_e;
endpackage
`default_nettype wire

// *** common/tally_if.sv ***
// Interface between the top and one saturating tally
`timescale 1ns/1ns
`default_nettype none
interface tally_if;
  logic       inc;     // Count one
  logic       clr;     // Clear on read
  logic [7:0] value;   // Current count
  logic       half;    // One-cycle pulse on crossing half-full
  modport owner (input inc, input clr, output value, output half);
  modport user  (output inc, output clr, input value, input half);
endinterface
`default_nettype wire

// *** hdl/sat_tally.sv ***
// Saturating clear-on-read 8-bit event counter with half-full pulse
`timescale 1ns/1ns
`include "phy_event_consts.svh"
`default_nettype none
module sat_tally (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // Counter port
  tally_if.owner    t
);
  logic [`TALLY_WIDTH-1:0] cnt_q;  // Count
  logic [`TALLY_WIDTH-1:0] cnt_d;
  logic                    half_q; // Half-full pulse
  logic                    half_d;

  ////////////////////////////////////////////////////////////////
  // Next count; an increment in the clearing cycle is kept
  always_comb begin
    cnt_d  = t.clr ? '0 : cnt_q;
    half_d = 1'b0;
    if (t.inc && cnt_d != `TALLY_MAX) begin
      cnt_d = cnt_d + 8'h01;
      // Edge into the upper half only, so one pulse per crossing
      half_d = (cnt_d == `TALLY_HALF);
    end
  end

  // Register stage
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt_q  <= '0;
      half_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      half_q <= half_d;
    end
  end

  assign t.value = cnt_q;
  assign t.half  = half_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  property p_sat_hold;
    @(posedge clk_i) disable iff (!resetn_i)
      (cnt_q == `TALLY_MAX && !t.clr) |=> cnt_q == `TALLY_MAX;
  endproperty
  a_sat_hold: assert property (p_sat_hold) else $error("tally wrapped");
  property p_half_once;
    @(posedge clk_i) disable iff (!resetn_i)
      half_q |-> cnt_q == `TALLY_HALF;
  endproperty
  a_half_once: assert property (p_half_once) else $error("half pulse wrong");
  c_sat: cover property (@(posedge clk_i) cnt_q == `TALLY_MAX);
endmodule
`default_nettype wire

// *** verification/mgmt_host.sv ***
// Station management controller model that drives the register port
`timescale 1ns/1ns
`default_nettype none
module mgmt_host (
  // Clock
  input  wire logic        clk_i,
  // Register port toward the block
  output logic      [4:0]  reg_addr_o,
  output logic             reg_rd_o,
  output logic             reg_wr_o,
  output logic      [15:0] reg_wdata_o,
  input  wire logic [15:0] reg_rdata_i
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle port values at time zero
  initial begin
    reg_addr_o  = 5'h00;
    reg_rd_o    = 1'b0;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle write strobe; data is scrambled afterwards so that a stale
  // value cannot be mistaken for a fresh write
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= v;
    reg_wr_o    <= 1'b1;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    reg_wdata_o <= ~v;
  endtask

  // One-cycle read strobe; the word is registered and stands one cycle
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge clk_i);
    reg_rd_o   <= 1'b0;
    @(negedge clk_i);
    v = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the event, interrupt and counter block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk_i    = 1'b0; // Device clock, 25 MHz
  logic        resetn_i = 1'b0; // Synchronous active-low reset
  logic [4:0]  reg_addr;        // Register port from the host model
  logic        reg_rd;
  logic        reg_wr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [4:0]  lv       = 5'h00; // Energy, link, speed, duplex, autoneg
  logic        fc       = 1'b0; // False carrier pulse
  logic        car      = 1'b0; // Receive carrier, symbol error, collision
  logic        serr     = 1'b0;
  logic        col      = 1'b0;
  logic        pin_in   = 1'b0; // Level an outside party puts on the pin
  logic        irq;
  logic        oe_n;
  logic        pdn;
  logic [15:0] d;               // Last word read
  int          errors   = 0;
  int          checked  = 0;
  // Pin level: the block drives it only while its enable is low
  wire         pin      = oe_n ? pin_in : irq;

  always #20 clk_i = ~clk_i;

  mgmt_host u_mgmt_host (.clk_i(clk_i), .reg_addr_o(reg_addr), .reg_rd_o(reg_rd),
    .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

  phy_event_irq u_phy_event_irq (.clk_i(clk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr), .reg_rd_i(reg_rd), .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .energy_i(lv[4]),
    .link_i(lv[3]), .speed_i(lv[2]), .duplex_i(lv[1]), .autoneg_done_i(lv[0]),
    .false_carrier_i(fc), .carrier_i(car), .symbol_err_i(serr),
    .collision_i(col), .powerdown_or_irq_pin_i(pin),
    .powerdown_or_irq_pin_o(irq), .powerdown_or_irq_pin_oe_o(oe_n),
    .powerdown_o(pdn));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    u_mgmt_host.rd(a, d);
    chk(d, e);
  endtask

  // Pin outputs are looked at mid-cycle, once edge updates have landed
  task automatic pchk(input logic e_irq, input logic e_oe);
    @(negedge clk_i);
    chk({14'h0000, irq, oe_n}, {14'h0000, e_irq, e_oe});
  endtask

  task automatic fpulse(input int n);
    repeat (n) begin
      @(posedge clk_i) fc <= 1'b1;
      @(posedge clk_i) fc <= 1'b0;
    end
  endtask

  // One carrier event with a number of bad symbols, optionally colliding
  task automatic frame(input int ne, input logic c);
    @(posedge clk_i) car <= 1'b1;
    col <= c;
    repeat (ne) begin
      @(posedge clk_i) serr <= 1'b1;
      @(posedge clk_i) serr <= 1'b0;
    end
    @(posedge clk_i) car <= 1'b0;
    col <= 1'b0;
    step(2);
  endtask

  task automatic test_done();
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_and_access();
    pchk(1'b0, 1'b1);
    rchk(5'h12, 16'h0000);
    rchk(5'h14, 16'h0000);
    rchk(5'h15, 16'h0000);
    u_mgmt_host.wr(5'h12, 16'hffff);
    rchk(5'h12, 16'h007f);
    u_mgmt_host.wr(5'h14, 16'hffff);
    u_mgmt_host.wr(5'h15, 16'hffff);
    rchk(5'h14, 16'h0000);
    rchk(5'h15, 16'h0000);
    rchk(5'h13, 16'h0000);
    u_mgmt_host.wr(5'h12, 16'h0000);
  endtask

  // Each of the five status-level events latched with every enable off, then cleared by the read
  task automatic t_events();
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i) lv[4-i] <= ~lv[4-i];
      step(2);
      rchk(5'h12, 16'h4000 >> i);
      rchk(5'h12, 16'h0000);
    end
  endtask

  task automatic t_irq_gating();
    u_mgmt_host.wr(5'h11, 16'h0001);
    u_mgmt_host.wr(5'h12, 16'h0040);
    @(posedge clk_i) lv[4] <= 1'b0;
    @(posedge clk_i) lv[4] <= 1'b1;
    step(3);
    pchk(1'b0, 1'b0);
    u_mgmt_host.wr(5'h11, 16'h0003);
    step(2);
    pchk(1'b1, 1'b0);
    rchk(5'h12, 16'h4040);
    step(2);
    pchk(1'b0, 1'b0);
    u_mgmt_host.wr(5'h11, 16'h0007);
    step(2);
    pchk(1'b1, 1'b0);
    rchk(5'h11, 16'h0007);
    u_mgmt_host.wr(5'h11, 16'h0000);
    @(posedge clk_i) pin_in <= 1'b1;
    step(5);
    pchk(1'b0, 1'b1);
    chk({15'h0000, pdn}, 16'h0001);
    @(posedge clk_i) pin_in <= 1'b0;
    u_mgmt_host.wr(5'h12, 16'h0000);
  endtask

  task automatic t_false_carrier();
    fpulse(127);
    step(2);
    rchk(5'h12, 16'h0000);
    fpulse(1);
    step(2);
    rchk(5'h12, 16'h0200);
    rchk(5'h14, 16'h0080);
    rchk(5'h14, 16'h0000);
    fpulse(300);
    rchk(5'h14, 16'h00ff);
    rchk(5'h12, 16'h0200);
  endtask

  task automatic t_rx_errors();
    frame(3, 1'b0);
    frame(2, 1'b1);
    frame(0, 1'b0);
    rchk(5'h15, 16'h0001);
    repeat (300) frame(1, 1'b0);
    rchk(5'h15, 16'h00ff);
    rchk(5'h12, 16'h0100);
    rchk(5'h15, 16'h0000);
  endtask

  // Reset in mid-run: controls, enables and tallies return to zero, and
  // levels that are high at release show up as fresh events
  task automatic t_midrun_reset();
    u_mgmt_host.wr(5'h12, 16'h007f);
    u_mgmt_host.wr(5'h11, 16'h0007);
    fpulse(3);
    pchk(1'b1, 1'b0);
    @(posedge clk_i) resetn_i <= 1'b0;
    step(4);
    resetn_i <= 1'b1;
    pchk(1'b0, 1'b1);
    rchk(5'h11, 16'h0000);
    rchk(5'h14, 16'h0000);
    u_mgmt_host.wr(5'h11, 16'h0003);
    step(2);
    pchk(1'b0, 1'b0);
    rchk(5'h12, 16'h7c00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and hang guard
  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset_and_access();
    t_events();
    t_irq_gating();
    t_false_carrier();
    t_rx_errors();
    t_midrun_reset();
    test_done();
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
